// ===== design/ais_consequent.sv
// Consequent actions: remote defect toward the far end and path alarm downstream.
// Assumes configuration is stable registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ais_consequent #(
  parameter int PATHS = ais_pkg::PATH_COUNT
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              defect,
  input  var  ais_pkg::config_type cfg,
  output logic                   rdi_send,
  output logic [PATHS-1:0]       path_alarm
);
  import ais_pkg::*;

  typedef struct packed {
    logic             rdi;
    logic [PATHS-1:0] alarm;
  } cons_type;

  cons_type q, d;
  logic     alarm_on;

  // Works out the actions from the defect and the enables.
  always_comb begin
    d = q;
    d.rdi = defect & cfg.rdi_control[RDI_ON_AIS_BIT];
    alarm_on = defect & cfg.auto_alarm[AUTO_ALARM_BIT];
    d.alarm = {PATHS{1'b0}};
    for (int i = 0; i < PATHS; i++) begin
      d.alarm[i] = alarm_on & ((i == 0) | cfg.single_channel);
    end
  end

  // Registers the actions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdi_send   = q.rdi;
  assign path_alarm = q.alarm;

  a_rdi_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 rdi_send == $past(defect && cfg.rdi_control[RDI_ON_AIS_BIT]))
    else $error("remote defect does not follow the defect");

  a_all_paths: assert property (@(posedge aclk) disable iff (!aresetn)
    defect && cfg.auto_alarm[AUTO_ALARM_BIT] && cfg.single_channel |=> &path_alarm)
    else $error("path alarm missing on a path");

  a_alarm_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    path_alarm[0] |-> $past(defect && cfg.auto_alarm[AUTO_ALARM_BIT]))
    else $error("path alarm without cause");

  c_all_paths: cover property (@(posedge aclk) disable iff (!aresetn) &path_alarm);
endmodule : ais_consequent
`default_nettype wire

// ===== design/ais_detector.sv
// Five-frame declare and clear filter for K2 bits 6 to 8.
// Assumes one frame strobe per received frame, with K2 valid at that strobe.
`timescale 1ns/1ps
`default_nettype none
module ais_detector #(
  parameter int FRAMES = ais_pkg::DETECT_FRAMES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              frame_strobe,
  input  wire logic [2:0]        k2_bits,
  output var  ais_pkg::defect_type defect_out
);
  import ais_pkg::*;

  typedef struct packed {
    det_state_type state;
    logic [3:0]    run;
    logic          change;
  } det_reg_type;

  det_reg_type q, d;
  logic        match;

  assign match = (k2_bits == K2_AIS_PATTERN);

  // Counts frames that oppose the present state and flips after FRAMES of them.
  always_comb begin
    d        = q;
    d.change = 1'b0;
    if (frame_strobe) begin
      if ((q.state == ST_CLEAR) != match) begin
        d.run = 4'h0;
      end else if (q.run == 4'(FRAMES - 1)) begin
        d.run    = 4'h0;
        d.change = 1'b1;
        case (q.state)
          ST_CLEAR:    d.state = ST_DECLARED;
          ST_DECLARED: d.state = ST_CLEAR;
          default:     d.state = ST_CLEAR;
        endcase
      end else begin
        d.run = q.run + 4'h1;
      end
    end
  end

  // Registers the detector state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{state: ST_CLEAR, run: 4'h0, change: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign defect_out = '{defect: (q.state == ST_DECLARED), change: q.change};

  a_declare_after_five: assert property (@(posedge aclk) disable iff (!aresetn)
    q.state == ST_CLEAR && q.change == 1'b0 && d.state == ST_DECLARED |->
      match && frame_strobe && q.run == 4'(FRAMES - 1))
    else $error("defect declared without a full run");

  a_clear_after_five: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(q.state == ST_DECLARED) |-> $past(!match && frame_strobe && q.run == 4'(FRAMES - 1)))
    else $error("defect cleared without a full run");

  a_run_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_strobe && ((q.state == ST_CLEAR) != match) |=> q.run == 4'h0)
    else $error("run counter not restarted");

  c_declare: cover property (@(posedge aclk) disable iff (!aresetn) $rose(q.state == ST_DECLARED));
  c_clear:   cover property (@(posedge aclk) disable iff (!aresetn) $fell(q.state == ST_DECLARED));
endmodule : ais_detector
`default_nettype wire

// ===== design/ais_pkg.sv
// Package for the line AIS defect monitor: register map, fields, counts and carriers.
// Assumes a 32-bit AXI4-Lite register bus and a frame strobe from the framer.
package ais_pkg;

  // ==========================================================================
  // Register map (printed offsets are not all word multiples, so they are indices).
  localparam logic [12:0] IDX_STATUS_BYTE1   = 13'h1106;
  localparam logic [12:0] IDX_INT_STATUS_B2  = 13'h1109;
  localparam logic [12:0] IDX_RDI_CONTROL    = 13'h1933;
  localparam logic [12:0] IDX_AUTO_ALARM     = 13'h1163;
  localparam logic [12:0] IDX_INT_MASK       = 13'h1110;
  localparam logic [12:0] IDX_MODE           = 13'h1111;
  localparam int          ADDR_W             = 15;

  // ==========================================================================
  // Field positions and reset values.
  localparam int          STATUS_AIS_BIT     = 0;
  localparam int          INT_AIS_BIT        = 1;
  localparam int          RDI_ON_AIS_BIT     = 2;
  localparam int          AUTO_ALARM_BIT     = 0;
  localparam int          MODE_SINGLE_BIT    = 0;
  localparam logic [3:0]  RDI_CONTROL_RESET  = 4'h0;
  localparam logic [7:0]  AUTO_ALARM_RESET   = 8'h00;
  localparam logic [7:0]  INT_MASK_RESET     = 8'h00;
  localparam logic        MODE_RESET         = 1'b0;

  // ==========================================================================
  // Detection figures.
  localparam int          DETECT_FRAMES      = 5;
  localparam logic [2:0]  K2_AIS_PATTERN     = 3'h7;
  localparam int          PATH_COUNT         = 3;

  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // One-hot detector states.
  typedef enum logic [1:0] {
    ST_CLEAR    = 2'b01,
    ST_DECLARED = 2'b10
  } det_state_type;

  // Configuration carried from the register file to the consequent logic.
  typedef struct packed {
    logic [3:0] rdi_control;
    logic [7:0] auto_alarm;
    logic       single_channel;
  } config_type;

  // Defect events from the detector.
  typedef struct packed {
    logic defect;
    logic change;
  } defect_type;

endpackage : ais_pkg

// ===== design/line_ais_defect_monitor.sv
// Overview of operation
// - Declare line AIS after five consecutive frames with K2 bits 6-8 all ones.
// - Clear line AIS after five consecutive frames with other K2 bits 6-8.
// - Status byte-1 bit 0 reads one while the defect is declared.
// - Declaration sets change flag bit 1, cleared on read; interrupt pin goes low.
// - Clearance sets the same change flag and asserts the interrupt too.
// - With control bit 2 set, send remote defect while line AIS declared.
// - Remote defect control: four read-write enables in bits 3-0; 7-4 read zero.
// - When enabled, send path alarm downstream while line AIS declared.
// - Single-channel mode drives the path alarm to all three path processors.
// - Bit 0 of the automatic alarm register enables downstream path alarm.
//
// Top of the line AIS defect monitor with its AXI4-Lite register slave.
// Assumes frame strobe and K2 bits arrive from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module line_ais_defect_monitor #(
  parameter int PATHS = ais_pkg::PATH_COUNT
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      frame_strobe,
  input  wire logic [2:0]                k2_bits,
  input  wire logic [ais_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ais_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           int_n,
  output logic                           rdi_send,
  output logic [PATHS-1:0]               path_alarm
);
  import ais_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic        aw_held;
    logic [12:0] aw_idx;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  rdi_control;
    logic [7:0]  auto_alarm;
    logic [7:0]  int_mask;
    logic        single_channel;
    logic        status_ais;
    logic        int_flag;
    logic        int_n;
  } top_type;

  top_type    q, d;
  defect_type det;
  config_type cfg;
  logic       do_write;
  logic       do_read;
  logic [12:0] ar_idx;
  logic [7:0]  rbyte;
  logic        rhit;

  // ==========================================================================
  // Sub-blocks
  ais_detector #(
    .FRAMES (DETECT_FRAMES)
  ) u_detector (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .frame_strobe (frame_strobe),
    .k2_bits      (k2_bits),
    .defect_out   (det)
  );

  assign cfg = '{rdi_control: q.rdi_control, auto_alarm: q.auto_alarm,
                 single_channel: q.single_channel};

  ais_consequent #(
    .PATHS (PATHS)
  ) u_consequent (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .defect     (det.defect),
    .cfg        (cfg),
    .rdi_send   (rdi_send),
    .path_alarm (path_alarm)
  );

  // ==========================================================================
  // Bus decode
  assign ar_idx   = s_axi_araddr[14:2];
  assign do_write = q.aw_held && q.w_held && !q.bvalid;
  assign do_read  = s_axi_arvalid && !q.rvalid;

  // Read multiplexer; unmapped indices answer with an error.
  always_comb begin
    rbyte = 8'h00;
    rhit  = 1'b1;
    case (ar_idx)
      IDX_STATUS_BYTE1:  rbyte[STATUS_AIS_BIT] = q.status_ais;
      IDX_INT_STATUS_B2: rbyte[INT_AIS_BIT]    = q.int_flag;
      IDX_RDI_CONTROL:   rbyte = {4'h0, q.rdi_control};
      IDX_AUTO_ALARM:    rbyte = q.auto_alarm;
      IDX_INT_MASK:      rbyte = q.int_mask;
      IDX_MODE:          rbyte[MODE_SINGLE_BIT] = q.single_channel;
      default:           rhit  = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    // Address and data are taken in either order and held until the write.
    if (s_axi_awvalid && !q.aw_held) begin
      d.aw_held = 1'b1;
      d.aw_idx  = s_axi_awaddr[14:2];
    end
    if (s_axi_wvalid && !q.w_held) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (do_write) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (q.w_strb[0]) begin
        case (q.aw_idx)
          IDX_RDI_CONTROL: d.rdi_control = q.w_data[3:0];
          IDX_AUTO_ALARM:  d.auto_alarm  = q.w_data[7:0];
          IDX_INT_MASK:    d.int_mask    = q.w_data[7:0];
          IDX_MODE:        d.single_channel = q.w_data[MODE_SINGLE_BIT];
          IDX_STATUS_BYTE1, IDX_INT_STATUS_B2: d.bresp = RESP_OKAY;
          default:         d.bresp = RESP_SLVERR;
        endcase
      end
    end
    if (do_read) begin
      d.rvalid = 1'b1;
      d.rdata  = {24'h000000, rbyte};
      d.rresp  = rhit ? RESP_OKAY : RESP_SLVERR;
      if (ar_idx == IDX_INT_STATUS_B2) begin
        d.int_flag = 1'b0;
      end
    end
    d.status_ais = det.defect;
    if (det.change) begin
      d.int_flag = 1'b1;
    end
    d.int_n = !(d.int_flag && !q.int_mask[INT_AIS_BIT]);
  end

  // Registers all state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q                <= '0;
      q.rdi_control    <= RDI_CONTROL_RESET;
      q.auto_alarm     <= AUTO_ALARM_RESET;
      q.int_mask       <= INT_MASK_RESET;
      q.single_channel <= MODE_RESET;
      q.int_n          <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready  = !q.w_held;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign int_n         = q.int_n;

  // ==========================================================================
  // Checks
  // status tracks defect
  a_status_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 q.status_ais == $past(det.defect))
    else $error("status bit does not track the defect");

  a_change_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    det.change |=> q.int_flag)
    else $error("change did not set the flag");

  a_int_low: assert property (@(posedge aclk) disable iff (!aresetn)
    det.change && !q.int_mask[INT_AIS_BIT] |=> !int_n)
    else $error("interrupt not asserted on change");

  a_ctrl_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    do_read && ar_idx == IDX_RDI_CONTROL |=> s_axi_rdata[7:4] == 4'h0)
    else $error("unused control bits read nonzero");

  c_int_read: cover property (@(posedge aclk) disable iff (!aresetn)
    do_read && ar_idx == IDX_INT_STATUS_B2 && q.int_flag);
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write);
endmodule : line_ais_defect_monitor
`default_nettype wire

// ===== tb/far_end_model.sv
// Far end model: sends received frames with a chosen K2 pattern.
// Assumes the bench raises run and sets the pattern between frames.
`timescale 1ns/1ps
`default_nettype none
module far_end_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] k2_send,
  output logic            frame_strobe,
  output logic [2:0]      k2_bits
);
  // ==========================================================================
  // Frame timing
  logic [2:0] phase_q;

  // One frame every eight cycles while run is high; K2 toggles between frames.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q      <= 3'h0;
      frame_strobe <= 1'b0;
      k2_bits      <= 3'h0;
    end else begin
      phase_q      <= phase_q + 3'h1;
      frame_strobe <= run && (phase_q == 3'h7);
      k2_bits      <= (run && (phase_q == 3'h7)) ? k2_send : ~k2_bits;
    end
  end
endmodule : far_end_model
`default_nettype wire

// ===== tb/line_ais_defect_monitor_test.sv
// Testbench of the line AIS defect monitor: frame rows, registers, interrupt.
// Assumes the far end model and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module line_ais_defect_monitor_test;
  import ais_pkg::*;
  typedef struct {logic [2:0] k2; int n; logic exp;} row_type;
  logic              aclk, aresetn, frame_strobe, run;
  logic [2:0]        k2_bits, k2_send, path_alarm;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_data;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rd_resp, wr_resp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, int_n, rdi_send;
  int                failures, comparisons, cycles;
  row_type rows[11] = '{'{3'h7,4,0}, '{3'h5,1,0}, '{3'h7,4,0}, '{3'h7,1,1},
    '{3'h6,4,1}, '{3'h7,1,1}, '{3'h1,2,1}, '{3'h2,2,1}, '{3'h4,1,0},
    '{3'h3,1,0}, '{3'h0,1,0}};

  far_end_model i_far (.aclk(aclk), .aresetn(aresetn), .run(run), .k2_send(k2_send),
    .frame_strobe(frame_strobe), .k2_bits(k2_bits));
  line_ais_defect_monitor i_dut (.aclk(aclk), .aresetn(aresetn),
    .frame_strobe(frame_strobe), .k2_bits(k2_bits), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .int_n(int_n), .rdi_send(rdi_send), .path_alarm(path_alarm));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      end_of_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write one word; address and data are released each as it is taken.
  task automatic wr(input logic [12:0] idx, input logic [31:0] d);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read one word and keep its data and response.
  task automatic rd(input logic [12:0] idx);
    logic a;
    a = 1'b1;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (a && arready) begin
        a = 1'b0;
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input string what, input logic [12:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(what, exp, rd_data);
    chk("rresp", 32'(RESP_OKAY), 32'(rd_resp));
  endtask : rdc

  // Sends n frames of one K2 value, then lets the outputs settle.
  task automatic frames(input logic [2:0] v, input int n);
    @(posedge aclk);
    k2_send <= v;
    run     <= 1'b1;
    repeat (n) begin
      do @(posedge aclk); while (!frame_strobe);
    end
    run <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : frames

  task automatic pins(input logic ni, input logic rs, input logic [2:0] pa);
    chk("int_n", 32'(ni), 32'(int_n));
    chk("rdi_send", 32'(rs), 32'(rdi_send));
    chk("path_alarm", 32'(pa), 32'(path_alarm));
  endtask : pins

  // ==========================================================================
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, run} = '0;
    {awaddr, araddr, wdata, k2_send, failures, comparisons, cycles} = '0;
    wstrb   = 4'hF;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pins(1'b1, 1'b0, 3'h0);
    rdc("status", IDX_STATUS_BYTE1, 32'h0);
    rdc("int status", IDX_INT_STATUS_B2, 32'h0);
    rdc("rdi control", IDX_RDI_CONTROL, 32'(RDI_CONTROL_RESET));
    rdc("auto alarm", IDX_AUTO_ALARM, 32'(AUTO_ALARM_RESET));
    rd(13'h0000);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rd_resp));
    chk("unmapped rdata", 32'h0, rd_data);
    wr(13'h0000, 32'h0000_00FF);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(wr_resp));
    wr(IDX_RDI_CONTROL, 32'h0000_00FF);
    chk("bresp", 32'(RESP_OKAY), 32'(wr_resp));
    rdc("rdi control", IDX_RDI_CONTROL, 32'h0000_000F);
    wstrb <= 4'h0;
    wr(IDX_RDI_CONTROL, 32'h0000_0000);
    wstrb <= 4'hF;
    chk("masked bresp", 32'(RESP_OKAY), 32'(wr_resp));
    rdc("rdi control kept", IDX_RDI_CONTROL, 32'h0000_000F);
    wr(IDX_AUTO_ALARM, 32'h0000_0001);
    wr(IDX_MODE, 32'h0000_0001);
    $display("test reset and registers done");
    // Rows walk declare, clear and broken runs with every K2 value.
    for (int i = 0; i < 11; i++) begin
      frames(rows[i].k2, rows[i].n);
      rdc("status", IDX_STATUS_BYTE1, 32'(rows[i].exp));
      chk("rdi_send", 32'(rows[i].exp), 32'(rdi_send));
      chk("path_alarm", 32'({3{rows[i].exp}}), 32'(path_alarm));
    end
    $display("test frame rows done");
    chk("int_n", 32'h0, 32'(int_n));
    rdc("int status", IDX_INT_STATUS_B2, 32'h2);
    repeat (2) @(posedge aclk);
    chk("int_n", 32'h1, 32'(int_n));
    rdc("int status", IDX_INT_STATUS_B2, 32'h0);
    wr(IDX_INT_MASK, 32'h2);
    rdc("int mask", IDX_INT_MASK, 32'h2);
    rdc("mode", IDX_MODE, 32'h1);
    frames(3'h7, 5);
    pins(1'b1, 1'b1, 3'h7);
    wr(IDX_INT_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("int_n", 32'h0, 32'(int_n));
    rdc("int status", IDX_INT_STATUS_B2, 32'h2);
    $display("test interrupt mask done");
    wr(IDX_RDI_CONTROL, 32'h0000_000B);
    wr(IDX_MODE, 32'h0);
    repeat (3) @(posedge aclk);
    pins(1'b1, 1'b0, 3'h1);
    wr(IDX_AUTO_ALARM, 32'h0);
    repeat (3) @(posedge aclk);
    pins(1'b1, 1'b0, 3'h0);
    frames(3'h0, 5);
    rdc("status", IDX_STATUS_BYTE1, 32'h0);
    chk("int_n", 32'h0, 32'(int_n));
    rdc("int status", IDX_INT_STATUS_B2, 32'h2);
    $display("test consequent enables done");
    wr(IDX_RDI_CONTROL, 32'h0000_0004);
    frames(3'h7, 5);
    chk("rdi_send", 32'h1, 32'(rdi_send));
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pins(1'b1, 1'b0, 3'h0);
    rdc("status", IDX_STATUS_BYTE1, 32'h0);
    rdc("rdi control", IDX_RDI_CONTROL, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule : line_ais_defect_monitor_test
`default_nettype wire
